/* verilog/sanitize_key_scramble_cmd.sv */
// Purpose: Sanitize key-scramble command interpreter behind an APB slave
// Assumes: Media engine reports only scramble failure via op_done/op_fail; success ends on the cycle count
// Notes:   Command issued by one write to the command word
// Behaviour
// - Feature 0011h selects key-scramble operation
// - Accept only when supported and idle/failed/succeeded
// - Acceptance starts internal key replacement
// - Report support only if keys cover all
// - User data undefined after scramble
// - Failure-mode one lets status leave failed
// - Failure-mode zero: abort mode-one while failed
// - Success flag set/cleared, kept over functional reset
// - In-progress flag while operation runs
// - Frozen flag while in frozen state
// - Progress numerator in one 16-bit field
// - Progress all ones when not running
// - Abort after freeze-lock since power-on; here functional reset presetn clears the lock history
// - Abort failed, prior mode zero, new one
// - Error code in sector-number field
`timescale 1ns/1ns
module sanitize_key_scramble_cmd #(
  parameter int SCRAMBLE_CYCLES = sanitize_pkg::SCRAMBLE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        cold_rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             key_replace,
  output logic             key_scramble_supported,
  output logic             user_data_undefined
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  sanitize_pkg::san_state_t state_q;      // Sanitize state machine
  sanitize_pkg::cmd_word_t  cmd;          // Written command word
  sanitize_pkg::result_t    result_q;     // Returned fields
  logic [1:0]  ctrl_q;                    // Supported and key coverage
  logic        fail_mode_q;               // Mode of last started op
  logic        freeze_seen_q;             // Freeze-lock since last functional reset presetn
  logic [31:0] op_cnt_q;                  // Scramble elapsed cycles
  logic [15:0] progress_q;                // Progress numerator
  logic [7:0]  err_code_q;                // Sanitize error code
  logic        undefined_q;               // Data area undefined
  logic        done_flag;                 // Persistent success flag
  logic        wr_acc;                    // Write access phase
  logic        cmd_wr;                    // Command word written
  logic        is_scram;
  logic        is_status;
  logic        is_freeze;
  logic        feat_known;
  logic        state_ok;
  logic        abort_mode;
  logic        accept;
  logic        op_end;
  logic        op_fail_in;
  logic        opdone_wr;
  logic        status_ok;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign cmd     = pwdata;
  assign cmd_wr  = wr_acc && (paddr == sanitize_pkg::ADDR_CMD) &&
                   (cmd.opcode == sanitize_pkg::OPC_SANITIZE);
  assign opdone_wr = wr_acc && (paddr == sanitize_pkg::ADDR_OPDONE);

  // Unmapped addresses answer with an error
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      if (paddr == sanitize_pkg::ADDR_CMD) begin
        pslverr = 1'b0;
      end else if (paddr == sanitize_pkg::ADDR_RESULT) begin
        pslverr = 1'b0;
      end else if (paddr == sanitize_pkg::ADDR_PROGRESS) begin
        pslverr = 1'b0;
      end else if (paddr == sanitize_pkg::ADDR_CTRL) begin
        pslverr = 1'b0;
      end else if (paddr == sanitize_pkg::ADDR_STATE) begin
        pslverr = 1'b0;
      end else if (paddr == sanitize_pkg::ADDR_OPDONE) begin
        pslverr = 1'b0;
      end else begin
        pslverr = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Command qualification
  // ----------------------------------------------------------------------
  // feature decode
  assign is_scram  = cmd.feature == sanitize_pkg::FEAT_KEY_SCRAM;
  assign is_status = cmd.feature == sanitize_pkg::FEAT_STATUS;
  assign is_freeze = cmd.feature == sanitize_pkg::FEAT_FREEZE;
  assign feat_known = is_scram || is_status || is_freeze;

  assign state_ok = ctrl_q[sanitize_pkg::CTRL_SUPP_BIT] &&
                    ctrl_q[sanitize_pkg::CTRL_ALLKEY_BIT] &&
                    ((state_q == sanitize_pkg::sanitize_idle_state) ||
                     (state_q == sanitize_pkg::sanitize_failed_state) ||
                     (state_q == sanitize_pkg::sanitize_succeeded_state));

  assign abort_mode = (state_q == sanitize_pkg::sanitize_failed_state) &&
                      !fail_mode_q &&
                      cmd.count[sanitize_pkg::FAIL_MODE_BIT];

  assign accept = cmd_wr && is_scram && state_ok && !abort_mode &&
                  !freeze_seen_q;

  // status leaves failed only with mode one
  assign status_ok = cmd_wr && is_status &&
                     ((state_q != sanitize_pkg::sanitize_failed_state) ||
                      fail_mode_q);

  // ----------------------------------------------------------------------
  // Operation timing
  // ----------------------------------------------------------------------
  assign op_fail_in = opdone_wr && pwdata[0];
  assign op_end = (state_q == sanitize_pkg::sanitize_running_state) &&
                  ((op_cnt_q == 32'(SCRAMBLE_CYCLES - 1)) || op_fail_in);

  // Elapsed cycle counter of the running scramble
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_cnt_q <= 32'h0000_0000;
    end else if (accept) begin
      op_cnt_q <= 32'h0000_0000;
    end else if (state_q == sanitize_pkg::sanitize_running_state) begin
      op_cnt_q <= op_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      progress_q <= 16'h0000;
    end else if (state_q == sanitize_pkg::sanitize_running_state) begin
      progress_q <= 16'((64'(op_cnt_q) * 64'(sanitize_pkg::PROGRESS_DEN))
                        / 64'(SCRAMBLE_CYCLES));
    end else begin
      progress_q <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Sanitize state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= sanitize_pkg::sanitize_idle_state;
    end else begin
      case (state_q)
        sanitize_pkg::sanitize_running_state: begin
          if (op_end) begin
            state_q <= op_fail_in ? sanitize_pkg::sanitize_failed_state
                                  : sanitize_pkg::sanitize_succeeded_state;
          end
        end
        sanitize_pkg::sanitize_frozen_state: begin
          state_q <= sanitize_pkg::sanitize_frozen_state;
        end
        default: begin
          if (accept) begin
            state_q <= sanitize_pkg::sanitize_running_state;
          end else if (status_ok && (state_q !=
                       sanitize_pkg::sanitize_idle_state)) begin
            state_q <= sanitize_pkg::sanitize_idle_state;
          end else if (cmd_wr && is_freeze &&
                       ctrl_q[sanitize_pkg::CTRL_SUPP_BIT] &&
                       (state_q == sanitize_pkg::sanitize_idle_state)) begin
            state_q <= sanitize_pkg::sanitize_frozen_state;
          end
        end
      endcase
    end
  end

  // Failure mode of the last started operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_mode_q <= 1'b0;
    end else if (accept) begin
      fail_mode_q <= cmd.count[sanitize_pkg::FAIL_MODE_BIT];
    end
  end

  // Freeze-lock history, cleared only by functional reset presetn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freeze_seen_q <= 1'b0;
    end else if (cmd_wr && is_freeze && ctrl_q[sanitize_pkg::CTRL_SUPP_BIT]
                 && (state_q == sanitize_pkg::sanitize_idle_state)) begin
      freeze_seen_q <= 1'b1;
    end
  end

  keep_flag u_done (
    .pclk      (pclk),
    .cold_rstn (cold_rstn),
    .set_en    (op_end && !op_fail_in),
    .clr_en    (accept),
    .flag_q    (done_flag)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      undefined_q <= 1'b0;
    end else if (accept) begin
      undefined_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Error code and returned fields
  // ----------------------------------------------------------------------
  // error code selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_code_q <= sanitize_pkg::ERR_NONE;
    end else if (op_end && op_fail_in) begin
      err_code_q <= sanitize_pkg::ERR_UNSANIT;
    end else if (cmd_wr) begin
      if (!feat_known) begin
        err_code_q <= sanitize_pkg::ERR_BAD_FEAT;
      end else if (state_q == sanitize_pkg::sanitize_frozen_state ||
                   (is_scram && freeze_seen_q)) begin
        err_code_q <= sanitize_pkg::ERR_FROZEN;
      end else begin
        err_code_q <= sanitize_pkg::ERR_NONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
      result_q.status[sanitize_pkg::STAT_RDY_BIT] <= 1'b1;
    end else if (cmd_wr) begin
      result_q.status <= 8'h40;
      result_q.error  <= 8'h00;
      if ((is_scram && !accept) || !feat_known ||
          (is_status && !status_ok)) begin
        result_q.error[sanitize_pkg::ERR_ABT_BIT]   <= 1'b1;
        result_q.status[sanitize_pkg::STAT_ERR_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control register and read mux
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= sanitize_pkg::CTRL_RESET;
    end else if (wr_acc && (paddr == sanitize_pkg::ADDR_CTRL)) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  assign key_scramble_supported = ctrl_q[sanitize_pkg::CTRL_SUPP_BIT] &&
                                  ctrl_q[sanitize_pkg::CTRL_ALLKEY_BIT];
  assign key_replace = accept;
  assign user_data_undefined = undefined_q;

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == sanitize_pkg::ADDR_RESULT) begin
      prdata[31:16] = {result_q.status, result_q.error};
      prdata[sanitize_pkg::RET_DONE_BIT] = done_flag;
      prdata[sanitize_pkg::RET_BUSYOP_BIT] =
        state_q == sanitize_pkg::sanitize_running_state;
      prdata[sanitize_pkg::RET_FROZEN_BIT] =
        state_q == sanitize_pkg::sanitize_frozen_state;
    end else if (paddr == sanitize_pkg::ADDR_PROGRESS) begin
      if (state_q == sanitize_pkg::sanitize_running_state) begin
        prdata[15:0] = progress_q;
      end else begin
        prdata[15:0] = sanitize_pkg::PROGRESS_IDLE;
      end
      prdata[23:16] = err_code_q;
    end else if (paddr == sanitize_pkg::ADDR_CTRL) begin
      prdata[1:0] = ctrl_q;
    end else if (paddr == sanitize_pkg::ADDR_STATE) begin
      prdata[2:0] = state_q;
    end
  end

endmodule : sanitize_key_scramble_cmd

/* verilog/sanitize_pkg.sv */
// Purpose: Shared constants and types for the sanitize key-scramble block
// Assumes: 32-bit APB, one clock pclk at 25 MHz
// Notes:   Register offsets are byte addresses, one aligned word each
package sanitize_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD      = 8'h00; // Command issue word
  localparam logic [7:0] ADDR_RESULT   = 8'h04; // Returned count/status
  localparam logic [7:0] ADDR_PROGRESS = 8'h08; // Progress and error code
  localparam logic [7:0] ADDR_CTRL     = 8'h0C; // Device configuration
  localparam logic [7:0] ADDR_STATE    = 8'h10; // State machine view
  localparam logic [7:0] ADDR_OPDONE   = 8'h14; // Media engine completion

  // ----------------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------------
  localparam int CMD_FEAT_LSB   = 0;   // Feature field 15:0
  localparam int CMD_COUNT_LSB  = 16;  // Count field 23:16
  localparam int CMD_OPCODE_LSB = 24;  // Command code 31:24
  localparam logic [7:0]  OPC_SANITIZE   = 8'hB4;
  localparam logic [15:0] FEAT_KEY_SCRAM = 16'h0011;
  localparam logic [15:0] FEAT_STATUS    = 16'h0000;
  localparam logic [15:0] FEAT_FREEZE    = 16'h0020;
  localparam int FAIL_MODE_BIT  = 4;   // Failure-mode bit of count field

  // ----------------------------------------------------------------------
  // Returned count field bits
  // ----------------------------------------------------------------------
  localparam int RET_DONE_BIT   = 15;
  localparam int RET_BUSYOP_BIT = 14;
  localparam int RET_FROZEN_BIT = 13;
  localparam logic [15:0] PROGRESS_IDLE = 16'hFFFF;
  localparam logic [16:0] PROGRESS_DEN  = 17'h10000;

  // Error codes
  localparam logic [7:0] ERR_NONE      = 8'h00;
  localparam logic [7:0] ERR_UNSANIT   = 8'h01;
  localparam logic [7:0] ERR_BAD_FEAT  = 8'h02;
  localparam logic [7:0] ERR_FROZEN    = 8'h03;

  // Status and error register bit positions
  localparam int STAT_BSY_BIT = 7;
  localparam int STAT_RDY_BIT = 6;
  localparam int STAT_ERR_BIT = 0;
  localparam int ERR_ABT_BIT  = 2;

  // Control register bits
  localparam int CTRL_SUPP_BIT  = 0;   // Sanitize feature supported
  localparam int CTRL_ALLKEY_BIT = 1;  // Keys cover all user data
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // Scramble duration
  localparam int  CLK_HZ        = 25_000_000;
  localparam int  SCRAMBLE_US   = 1000;
  localparam int  SCRAMBLE_CYC  = SCRAMBLE_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    sanitize_idle_state      = 3'h0,
    sanitize_running_state   = 3'h1,
    sanitize_succeeded_state = 3'h3,
    sanitize_failed_state    = 3'h2,
    sanitize_frozen_state    = 3'h6
  } san_state_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  count;
    logic [15:0] feature;
  } cmd_word_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
    logic [15:0] count;
  } result_t;

endpackage : sanitize_pkg

/* verilog/keep_flag.sv */
// Purpose: Flag holder that survives a functional reset
// Assumes: Only the cold-start reset clears it; functional reset does not
// Notes:   Models the nonvolatile record of the last sanitize outcome
`timescale 1ns/1ns
module keep_flag (
  input  wire logic pclk,
  input  wire logic cold_rstn,
  input  wire logic set_en,
  input  wire logic clr_en,
  output logic      flag_q
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Set wins when both arrive together so a success is never lost
  always_ff @(posedge pclk or negedge cold_rstn) begin
    if (!cold_rstn) begin
      flag_q <= 1'b0;
    end else if (set_en) begin
      flag_q <= 1'b1;
    end else if (clr_en) begin
      flag_q <= 1'b0;
    end
  end

endmodule : keep_flag

/* sim/san_cmd_asserts.sv */
// Purpose: Port checks for the sanitize command block
// Assumes: Zero-wait APB slave on one clock
// Notes:   Helpers mirror config and the scramble window
`timescale 1ns/1ns
module san_cmd_asserts #(
  parameter int SCRAMBLE_CYCLES = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        cold_rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        key_replace,
  input wire logic        key_scramble_supported,
  input wire logic        user_data_undefined
);
  logic [1:0] ctrl_q; // Config mirror
  logic       run_q;  // Window ends two late: safe both ways
  int         cnt_q;  // Cycles in window
  logic       acc;    // Access phase
  logic       mapd;   // Mapped address
  logic       rd_res; // Result read
  logic       rd_prg; // Progress read
  assign acc    = psel & penable;
  assign mapd   = (paddr <= 8'h14) & (paddr[1:0] == 2'h0);
  assign rd_res = acc & !pwrite & (paddr == sanitize_pkg::ADDR_RESULT);
  assign rd_prg = acc & !pwrite & (paddr == sanitize_pkg::ADDR_PROGRESS);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Config mirror follows writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= sanitize_pkg::CTRL_RESET;
    end else if (acc & pwrite & (paddr == sanitize_pkg::ADDR_CTRL)) begin
      ctrl_q <= pwdata[1:0];
    end
  end
  // Scramble window from accept to end or failure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      cnt_q <= 0;
    end else if (key_replace) begin
      run_q <= 1'b1;
      cnt_q <= 0;
    end else if ((acc & pwrite & pwdata[0]
                  & (paddr == sanitize_pkg::ADDR_OPDONE))
                 | (cnt_q == SCRAMBLE_CYCLES + 1)) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q + 1;
    end
  end
  a_zero_wait: assert property (acc |-> pready)
    else $error("slave inserted a wait state");
  a_unmapped_err: assert property (acc & !mapd |-> pslverr
    & (pwrite | (prdata == 32'h0))) else $error("unmapped not refused");
  a_mapped_ok: assert property (acc & mapd |-> !pslverr)
    else $error("mapped access refused");
  a_support_level: assert property (
    key_scramble_supported == (ctrl_q == 2'h3))
    else $error("support flag wrong");
  a_replace_cause: assert property (key_replace |-> acc & pwrite
    & (paddr == sanitize_pkg::ADDR_CMD) & (ctrl_q == 2'h3)
    & (pwdata[15:0] == sanitize_pkg::FEAT_KEY_SCRAM)
    & (pwdata[31:24] == sanitize_pkg::OPC_SANITIZE))
    else $error("key replace without valid command");
  a_replace_pulse: assert property (key_replace |=> !key_replace)
    else $error("key replace longer than one cycle");
  a_undef_after: assert property (
    key_replace |=> user_data_undefined [*4])
    else $error("user data not marked undefined");
  a_progress_idle: assert property (
    rd_prg & !run_q & !$past(run_q) |-> prdata[15:0] == 16'hFFFF)
    else $error("progress not all ones when idle");
  a_running_flag: assert property (rd_res & run_q & (cnt_q >= 1)
    & (cnt_q < SCRAMBLE_CYCLES - 1) |-> prdata[14])
    else $error("in-progress flag low while running");
  a_busy_clear: assert property (rd_res |-> !prdata[31] & prdata[30])
    else $error("busy set or ready low at completion");
  a_abort_err: assert property (rd_res & prdata[18] |-> prdata[24])
    else $error("abort without error status");
  c_replace: cover property (key_replace);
  c_abort: cover property (rd_res & prdata[18]);
  c_refuse: cover property (acc & pslverr);
endmodule : san_cmd_asserts

bind sanitize_key_scramble_cmd san_cmd_asserts #(
  .SCRAMBLE_CYCLES(SCRAMBLE_CYCLES)
) san_cmd_asserts_inst (
  .pclk(pclk), .presetn(presetn), .cold_rstn(cold_rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .key_replace(key_replace),
  .key_scramble_supported(key_scramble_supported),
  .user_data_undefined(user_data_undefined)
);

/* sim/ata_host_model.sv */
// Purpose: Host side issuing sanitize commands over APB
// Assumes: Signals change only after a rising edge
// Notes:   Released bus shows inverted data, never stale values
`timescale 1ns/1ns
module ata_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'hFF;
    pwdata  = 32'h0;
  end
  // One transfer; request held until pready seen high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    logic rdy;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the rising edge only; bench timeout ends a hang
    do begin
      @(posedge pclk);
      rdy = pready;
      q   = prdata;
      err = pslverr;
    end while (rdy !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q,
                    output logic e);
    xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic cmd(input logic [7:0] cnt, input logic [15:0] feat);
    wr(sanitize_pkg::ADDR_CMD, {sanitize_pkg::OPC_SANITIZE, cnt, feat});
  endtask : cmd
endmodule : ata_host_model

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the sanitize command block
// Assumes: Short scramble count so runs stay brief
// Notes:   Host model drives APB; bench owns resets
`timescale 1ns/1ns
module tb_top;
  localparam int         SCR = 20;    // Shortened scramble
  localparam logic [7:0] FM1 = 8'h10; // Failure-mode one
  logic pclk = 1'b0;
  logic presetn, cold_rstn, psel, penable, pwrite, pready, pslverr;
  logic key_replace, key_scramble_supported, user_data_undefined;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        e;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 pclk = ~pclk;
  sanitize_key_scramble_cmd #(.SCRAMBLE_CYCLES(SCR))
    sanitize_key_scramble_cmd_inst (
    .pclk(pclk), .presetn(presetn), .cold_rstn(cold_rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_replace(key_replace),
    .key_scramble_supported(key_scramble_supported),
    .user_data_undefined(user_data_undefined));
  ata_host_model ata_host_model_inst (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic get(input logic [7:0] a);
    ata_host_model_inst.rd(a, r, e);
  endtask : get
  task automatic st(input sanitize_pkg::san_state_t s);
    get(sanitize_pkg::ADDR_STATE);
    chk(32'(r[2:0]), 32'(s));
  endtask : st
  task automatic run(input logic [7:0] c, input logic [15:0] f);
    ata_host_model_inst.cmd(c, f);
  endtask : run
  task automatic fail_op();
    ata_host_model_inst.wr(sanitize_pkg::ADDR_OPDONE, 32'h1);
  endtask : fail_op
  task automatic rst_pulse(input logic cold);
    @(posedge pclk);
    if (cold) cold_rstn <= 1'b0;
    else presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    cold_rstn <= 1'b1;
    presetn   <= 1'b1;
  endtask : rst_pulse
  task automatic t_scramble_ok();
    get(sanitize_pkg::ADDR_CTRL);
    chk(32'(r[1:0]), 32'(sanitize_pkg::CTRL_RESET));
    run(8'h00, sanitize_pkg::FEAT_KEY_SCRAM);
    get(sanitize_pkg::ADDR_RESULT);
    chk(32'(r[15:13]), 32'h2);
    get(sanitize_pkg::ADDR_PROGRESS);
    chk(32'(r[15:0] === 16'hFFFF), 32'h0);
    repeat (SCR + 5) @(posedge pclk);
    st(sanitize_pkg::sanitize_succeeded_state);
    get(sanitize_pkg::ADDR_RESULT);
    chk(32'(r[15:13]), 32'h4);
    get(sanitize_pkg::ADDR_PROGRESS);
    chk(32'(r[15:0]), 32'hFFFF);
    chk(32'(user_data_undefined), 32'h1);
    $display("t_scramble_ok done");
  endtask : t_scramble_ok
  task automatic t_keep_flag();
    rst_pulse(1'b0);
    get(sanitize_pkg::ADDR_RESULT);
    chk(32'(r[15]), 32'h1);
    rst_pulse(1'b1);
    get(sanitize_pkg::ADDR_RESULT);
    chk(32'(r[15]), 32'h0);
    $display("t_keep_flag done");
  endtask : t_keep_flag
  task automatic t_fail_modes();
    run(8'h00, sanitize_pkg::FEAT_KEY_SCRAM);
    fail_op();
    st(sanitize_pkg::sanitize_failed_state);
    get(sanitize_pkg::ADDR_PROGRESS);
    chk(32'(r[23:16]), 32'(sanitize_pkg::ERR_UNSANIT));
    run(FM1, sanitize_pkg::FEAT_KEY_SCRAM);
    get(sanitize_pkg::ADDR_RESULT);
    chk(32'({r[31], r[24], r[18]}), 32'h3);
    st(sanitize_pkg::sanitize_failed_state);
    run(8'h00, sanitize_pkg::FEAT_STATUS);
    st(sanitize_pkg::sanitize_failed_state);
    run(8'h00, sanitize_pkg::FEAT_KEY_SCRAM);
    repeat (SCR + 5) @(posedge pclk);
    st(sanitize_pkg::sanitize_succeeded_state);
    run(FM1, sanitize_pkg::FEAT_KEY_SCRAM);
    fail_op();
    run(8'h00, sanitize_pkg::FEAT_STATUS);
    st(sanitize_pkg::sanitize_idle_state);
    $display("t_fail_modes done");
  endtask : t_fail_modes
  task automatic t_bad_cfg();
    run(8'h00, 16'h0005);
    get(sanitize_pkg::ADDR_PROGRESS);
    chk(32'(r[23:16]), 32'(sanitize_pkg::ERR_BAD_FEAT));
    get(sanitize_pkg::ADDR_RESULT);
    chk(32'({r[24], r[18]}), 32'h3);
    ata_host_model_inst.wr(sanitize_pkg::ADDR_CTRL, 32'h1);
    // Let the config write settle before looking at the level
    @(posedge pclk);
    chk(32'(key_scramble_supported), 32'h0);
    run(8'h00, sanitize_pkg::FEAT_KEY_SCRAM);
    st(sanitize_pkg::sanitize_idle_state);
    ata_host_model_inst.wr(sanitize_pkg::ADDR_CTRL, 32'h3);
    ata_host_model_inst.rd(8'h20, r, e);
    chk({r[30:0], e}, 32'h1);
    $display("t_bad_cfg done");
  endtask : t_bad_cfg
  task automatic t_freeze();
    run(8'h00, sanitize_pkg::FEAT_FREEZE);
    st(sanitize_pkg::sanitize_frozen_state);
    get(sanitize_pkg::ADDR_RESULT);
    chk(32'(r[14:13]), 32'h1);
    run(8'h00, sanitize_pkg::FEAT_KEY_SCRAM);
    get(sanitize_pkg::ADDR_RESULT);
    chk(32'({r[24], r[18]}), 32'h3);
    get(sanitize_pkg::ADDR_PROGRESS);
    chk(32'(r[23:16]), 32'(sanitize_pkg::ERR_FROZEN));
    rst_pulse(1'b0);
    st(sanitize_pkg::sanitize_idle_state);
    $display("t_freeze done");
  endtask : t_freeze
  task automatic final_report();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // Cut a hang short well past the expected run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    presetn   = 1'b0;
    cold_rstn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn   <= 1'b1;
    cold_rstn <= 1'b1;
    t_scramble_ok();
    t_keep_flag();
    t_fail_modes();
    t_bad_cfg();
    t_freeze();
    final_report();
  end
endmodule : tb_top
